// ===== ess_pkg.sv
package ess_pkg;
    localparam logic [31:0] ESS_EXP_CFG1_ADDR  = 32'hc400_0024;
    localparam logic [31:0] ESS_CORE_CTRL_ADDR = 32'hc400_0100;
    localparam logic [31:0] ESS_STATUS_ADDR    = 32'hc400_0104;
    localparam int          ESS_BIG_END_BIT    = 7;
    localparam int          ESS_SWAP_EN_BIT    = 8;
    localparam int          ESS_FORCE_BIT      = 9;
    localparam int          ESS_EXP_SWAP_BIT   = 10;
    localparam logic [31:0] ESS_CFG1_RESET     = 32'h0000_0000;
    localparam logic [31:0] ESS_CTRL_RESET     = 32'h0000_0000;
    localparam logic [1:0]  ESS_HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  ESS_HTRANS_SEQ     = 2'h3;
    localparam logic [1:0]  ESS_SIZE_BYTE      = 2'h0;
    localparam logic [1:0]  ESS_SIZE_HALF      = 2'h1;
    localparam logic [1:0]  ESS_SUBWORD_MASK   = 2'h3;
    localparam logic [1:0]  ESS_HALF_MASK      = 2'h2;
    localparam int          ESS_PAGE_MSB       = 31;
    localparam int          ESS_PAGE_LSB       = 20;
    typedef enum logic [2:0] {
        ESS_MODE_BIG  = 3'h1,
        ESS_MODE_ADDR = 3'h2,
        ESS_MODE_DATA = 3'h4
    } ess_mode_t;
endpackage

// ===== ess_lane_swap.sv
`timescale 1ns/1ns
// Byte lane reversal of one data word
module ess_lane_swap (
    input  wire logic        swap,
    input  wire logic [31:0] din,
    output logic      [31:0] dout
);
    always_comb begin
        dout = swap ? {din[7:0], din[15:8], din[23:16], din[31:24]} : din;
    end
endmodule

// ===== endian_swap_select.sv
`timescale 1ns/1ns
// Summary of operation
// - Core byte order comes from control bit 7; one is big-endian.
// - After reset: little-endian, address-coherent, memory management disabled.
// - Byte-order bit acts whether or not memory management is enabled.
// - Coherency enables live in expansion config register at 0xc4000024.
// - Swap-select enable bit 8 affects core transactions only.
// - Little-endian, enable set, force bit 9 clear: page attribute one data-coherent, zero address-coherent.
// - Little-endian, enable and force bit 9 clear: always address-coherent, page attribute ignored.
// - Big-endian core: enable and page attribute ignored, pass unchanged.
// - Force bit 9 with little-endian: data-coherent swap for every core transaction.
// - Bit 10 selects byte swap for expansion-bus master transfers.
// - One coherency attribute per 1-Mbyte page, sent with each access.
// - Address-coherent keeps words; bytes mirror lanes, half-words swap halves.
// - Data-coherent keeps bytes at their addresses, reversing words and halves.
module endian_swap_select
    import ess_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        core_valid,
    input  wire logic [31:0] core_addr,
    input  wire logic [1:0]  core_size,
    input  wire logic        core_page_attr,
    input  wire logic [31:0] core_wdata,
    input  wire logic [31:0] sys_rdata,
    input  wire logic        exp_valid,
    input  wire logic [31:0] exp_wdata,
    input  wire logic [31:0] exp_sys_rdata,
    output logic             sys_valid,
    output logic      [31:0] sys_addr,
    output logic      [31:0] sys_wdata,
    output logic      [31:0] core_rdata,
    output logic      [2:0]  core_mode,
    output logic             core_page_attr_out,
    output logic             exp_sys_valid,
    output logic      [31:0] exp_sys_wdata,
    output logic      [31:0] exp_rdata,
    output logic             big_endian_out
);
    ////////////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [31:0] cfg1_reg;
    logic [31:0] cfg1_next;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic        wr_pend_reg;
    logic        wr_pend_next;
    logic [31:0] wr_addr_reg;
    logic [31:0] wr_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic        bus_start;

    assign bus_start = hsel && hready && (htrans == ESS_HTRANS_NONSEQ || htrans == ESS_HTRANS_SEQ);

    always_comb begin
        cfg1_next    = cfg1_reg;
        ctrl_next    = ctrl_reg;
        wr_pend_next = bus_start && hwrite;
        wr_addr_next = bus_start ? haddr : wr_addr_reg;
        hrdata_next  = hrdata_reg;
        if (wr_pend_reg) begin
            if (wr_addr_reg == ESS_EXP_CFG1_ADDR) begin
                cfg1_next = hwdata;
            end else if (wr_addr_reg == ESS_CORE_CTRL_ADDR) begin
                ctrl_next = hwdata;
            end
        end
        if (bus_start && !hwrite) begin
            if (haddr == ESS_EXP_CFG1_ADDR) begin
                hrdata_next = cfg1_reg;
            end else if (haddr == ESS_CORE_CTRL_ADDR) begin
                hrdata_next = ctrl_reg;
            end else if (haddr == ESS_STATUS_ADDR) begin
                hrdata_next = {29'h0, core_mode};
            end else begin
                hrdata_next = 32'h0000_0000;
            end
        end
    end

    // Reset to little-endian, no swap enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg1_reg    <= ESS_CFG1_RESET;
            ctrl_reg    <= ESS_CTRL_RESET;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
            hrdata_reg  <= 32'h0000_0000;
        end else begin
            cfg1_reg    <= cfg1_next;
            ctrl_reg    <= ctrl_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////////
    // Mode selection
    logic      big_endian;
    logic      swap_en;
    logic      force_swap;
    logic      exp_swap;
    ess_mode_t mode;

    // No dependence on memory management state
    assign big_endian = ctrl_reg[ESS_BIG_END_BIT];
    assign swap_en    = cfg1_reg[ESS_SWAP_EN_BIT];
    assign force_swap = cfg1_reg[ESS_FORCE_BIT];
    assign exp_swap   = cfg1_reg[ESS_EXP_SWAP_BIT];

    always_comb begin
        if (big_endian) begin
            mode = ESS_MODE_BIG;
        end else if (force_swap) begin
            mode = ESS_MODE_DATA;
        end else if (swap_en) begin
            mode = core_page_attr ? ESS_MODE_DATA : ESS_MODE_ADDR;
        end else begin
            mode = ESS_MODE_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Core path
    logic        data_swap;
    logic [31:0] core_wswap;
    logic [31:0] core_rswap;
    logic [31:0] core_addr_conv;
    logic [1:0]  low_flip;

    assign data_swap = (mode == ESS_MODE_DATA);

    always_comb begin
        low_flip = 2'h0;
        if (mode == ESS_MODE_ADDR) begin
            if (core_size == ESS_SIZE_BYTE) begin
                low_flip = ESS_SUBWORD_MASK;
            end else if (core_size == ESS_SIZE_HALF) begin
                low_flip = ESS_HALF_MASK;
            end
        end
        core_addr_conv = {core_addr[31:2], core_addr[1:0] ^ low_flip};
    end

    ess_lane_swap u_core_wr (
        .swap (data_swap),
        .din  (core_wdata),
        .dout (core_wswap)
    );
    ess_lane_swap u_core_rd (
        .swap (data_swap),
        .din  (sys_rdata),
        .dout (core_rswap)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // Expansion-bus master path
    logic [31:0] exp_wswap;
    logic [31:0] exp_rswap;

    ess_lane_swap u_exp_wr (
        .swap (exp_swap),
        .din  (exp_wdata),
        .dout (exp_wswap)
    );
    ess_lane_swap u_exp_rd (
        .swap (exp_swap),
        .din  (exp_sys_rdata),
        .dout (exp_rswap)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // Core output registers
    logic        sys_valid_reg;
    logic        sys_valid_next;
    logic [31:0] sys_addr_reg;
    logic [31:0] sys_addr_next;
    logic [31:0] sys_wdata_reg;
    logic [31:0] sys_wdata_next;
    logic [31:0] core_rdata_reg;
    logic [31:0] core_rdata_next;
    logic [2:0]  core_mode_reg;
    logic [2:0]  core_mode_next;
    logic        page_attr_reg;
    logic        page_attr_next;
    logic        big_reg;
    logic        big_next;

    always_comb begin
        sys_valid_next  = core_valid;
        sys_addr_next   = core_addr_conv;
        sys_wdata_next  = core_wswap;
        core_rdata_next = core_rswap;
        core_mode_next  = mode;
        page_attr_next  = core_page_attr;
        big_next        = big_endian;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_valid_reg  <= 1'b0;
            sys_addr_reg   <= 32'h0000_0000;
            sys_wdata_reg  <= 32'h0000_0000;
            core_rdata_reg <= 32'h0000_0000;
            core_mode_reg  <= ESS_MODE_ADDR;
            page_attr_reg  <= 1'b0;
            big_reg        <= 1'b0;
        end else begin
            sys_valid_reg  <= sys_valid_next;
            sys_addr_reg   <= sys_addr_next;
            sys_wdata_reg  <= sys_wdata_next;
            core_rdata_reg <= core_rdata_next;
            core_mode_reg  <= core_mode_next;
            page_attr_reg  <= page_attr_next;
            big_reg        <= big_next;
        end
    end

    assign sys_valid          = sys_valid_reg;
    assign sys_addr           = sys_addr_reg;
    assign sys_wdata          = sys_wdata_reg;
    assign core_rdata         = core_rdata_reg;
    assign core_mode          = core_mode_reg;
    assign core_page_attr_out = page_attr_reg;
    assign big_endian_out     = big_reg;

    ////////////////////////////////////////////////////////////////////////////////////
    // Expansion output registers
    logic        exp_valid_reg;
    logic        exp_valid_next;
    logic [31:0] exp_wdata_reg;
    logic [31:0] exp_wdata_next;
    logic [31:0] exp_rdata_reg;
    logic [31:0] exp_rdata_next;

    always_comb begin
        exp_valid_next = exp_valid;
        exp_wdata_next = exp_wswap;
        exp_rdata_next = exp_rswap;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exp_valid_reg <= 1'b0;
            exp_wdata_reg <= 32'h0000_0000;
            exp_rdata_reg <= 32'h0000_0000;
        end else begin
            exp_valid_reg <= exp_valid_next;
            exp_wdata_reg <= exp_wdata_next;
            exp_rdata_reg <= exp_rdata_next;
        end
    end

    assign exp_sys_valid = exp_valid_reg;
    assign exp_sys_wdata = exp_wdata_reg;
    assign exp_rdata     = exp_rdata_reg;
endmodule

// ===== ess_bus_model.sv
`timescale 1ns/1ns
// System bus target holding one word
module ess_bus_model (
    input  wire logic        hclk,
    input  wire logic        sys_valid,
    input  wire logic [31:0] sys_wdata,
    output logic      [31:0] sys_rdata
);
always_ff @(posedge hclk) begin
    if (sys_valid) begin
        sys_rdata <= sys_wdata;
    end
end
endmodule

// ===== ess_chk.sv
`timescale 1ns/1ns
module ess_chk
    import ess_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        core_valid,
    input wire logic [31:0] core_addr,
    input wire logic [1:0]  core_size,
    input wire logic [31:0] core_wdata,
    input wire logic [31:0] sys_rdata,
    input wire logic        sys_valid,
    input wire logic [31:0] sys_addr,
    input wire logic [31:0] sys_wdata,
    input wire logic [31:0] core_rdata,
    input wire logic [2:0]  core_mode,
    input wire logic        big_endian_out
);
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
function automatic logic [31:0] lanes_rev(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
endfunction
sequence s_byte;
    core_valid && core_size == ESS_SIZE_BYTE ##1 core_mode == ESS_MODE_ADDR;
endsequence
sequence s_half;
    core_valid && core_size == ESS_SIZE_HALF ##1 core_mode == ESS_MODE_ADDR;
endsequence
a_no_wait: assert property (hreadyout && !hresp)
    else $error("wait or error response");
a_valid_next: assert property (core_valid |=> sys_valid)
    else $error("sys_valid late");
a_big_mode: assert property (big_endian_out == (core_mode == ESS_MODE_BIG))
    else $error("mode and byte order disagree");
a_mode_onehot: assert property ($onehot(core_mode))
    else $error("mode not one-hot");
a_byte_mirror: assert property (s_byte |-> sys_addr == ($past(core_addr) ^ 32'h3))
    else $error("byte lane not mirrored");
a_half_mirror: assert property (s_half |-> sys_addr == ($past(core_addr) ^ 32'h2))
    else $error("half-word not mirrored");
a_addr_keep: assert property ($past(core_valid) && core_mode != ESS_MODE_ADDR
    |-> sys_addr == $past(core_addr))
    else $error("address changed");
a_data_swap: assert property ($past(core_valid) && core_mode == ESS_MODE_DATA
    |-> sys_wdata == lanes_rev($past(core_wdata)))
    else $error("write lanes not reversed");
a_word_keep: assert property ($past(core_valid) && core_mode != ESS_MODE_DATA
    |-> sys_wdata == $past(core_wdata))
    else $error("write data changed");
a_read_swap: assert property ($past(core_valid) && core_mode == ESS_MODE_DATA
    |-> core_rdata == lanes_rev($past(sys_rdata)))
    else $error("read lanes not reversed");
endmodule
bind endian_swap_select ess_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .core_valid,
    .core_addr, .core_size, .core_wdata, .sys_rdata, .sys_valid, .sys_addr, .sys_wdata,
    .core_rdata, .core_mode, .big_endian_out);

// ===== tb.sv
`timescale 1ns/1ns
module tb
    import ess_pkg::*;
;
logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, core_valid;
logic [1:0]  htrans, core_size;
logic [2:0]  hsize, core_mode;
logic [31:0] haddr, hwdata, hrdata, core_addr, core_wdata, sys_rdata, exp_wdata, rd;
logic [31:0] exp_sys_rdata, sys_addr, sys_wdata, core_rdata, exp_sys_wdata, exp_rdata;
logic        core_page_attr, exp_valid, sys_valid, attr_out, exp_sys_valid, big_endian_out;
int          error_cnt = 0, comparisons = 0, cycles = 0;
assign hready = hreadyout;
endian_swap_select dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .core_valid, .core_addr, .core_size,
    .core_page_attr, .core_wdata, .sys_rdata, .exp_valid, .exp_wdata, .exp_sys_rdata,
    .sys_valid, .sys_addr, .sys_wdata, .core_rdata, .core_mode, .core_page_attr_out(attr_out),
    .exp_sys_valid, .exp_sys_wdata, .exp_rdata, .big_endian_out);
ess_bus_model u_sys (.hclk, .sys_valid, .sys_wdata, .sys_rdata);
ess_bus_model u_exp (.hclk, .sys_valid(exp_sys_valid), .sys_wdata(exp_sys_wdata),
    .sys_rdata(exp_sys_rdata));
function automatic logic [31:0] rev(logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
endfunction
task end_sim;
    $display("Comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask
task chk(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
        $display("Error %s expected %h seen %h", n, e, s);
        error_cnt++;
    end
endtask
task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= ESS_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
endtask
task core(input logic [31:0] a, input logic [1:0] sz, input logic p, input logic [31:0] w);
    @(posedge hclk);
    core_valid <= 1'b1;
    exp_valid <= 1'b1;
    core_addr <= a;
    core_size <= sz;
    core_page_attr <= p;
    core_wdata <= w;
    exp_wdata <= ~w;
    @(posedge hclk);
    core_valid <= 1'b0;
    exp_valid <= 1'b0;
    #1;
endtask
task t_reset;
    chk("core_mode", 32'(ESS_MODE_ADDR), 32'(core_mode));
    chk("big_endian_out", 32'h0, 32'(big_endian_out));
    bus(1'b0, ESS_EXP_CFG1_ADDR, 32'h0, rd);
    chk("cfg reset", ESS_CFG1_RESET, rd);
    bus(1'b0, ESS_CORE_CTRL_ADDR, 32'h0, rd);
    chk("ctrl reset", ESS_CTRL_RESET, rd);
    bus(1'b1, ESS_EXP_CFG1_ADDR, 32'h0000_0700, rd);
    bus(1'b0, ESS_EXP_CFG1_ADDR, 32'h0, rd);
    chk("cfg", 32'h0000_0700, rd);
    bus(1'b1, 32'hc400_0200, 32'hffff_ffff, rd);
    bus(1'b0, 32'hc400_0200, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
endtask
task t_modes;
    logic [2:0]  m;
    logic [31:0] a, w, x;
    for (int i = 0; i < 16; i++) begin
        m = i[3] ? ESS_MODE_BIG : (i[2] || i[1] && i[0]) ? ESS_MODE_DATA : ESS_MODE_ADDR;
        a = {(m == ESS_MODE_DATA && i[0]) ? 8'h48 : 8'h00, 4'(i), 20'h00004};
        w = 32'h1122_3300 + 32'(i);
        x = (i % 3 == 2) ? 32'h0 : (i % 3 == 0) ? 32'h3 : 32'h2;
        bus(1'b1, ESS_CORE_CTRL_ADDR, 32'(i[3]) << ESS_BIG_END_BIT, rd);
        bus(1'b1, ESS_EXP_CFG1_ADDR, 32'(i[2:1]) << ESS_SWAP_EN_BIT, rd);
        core(a, 2'(i % 3), i[0], w);
        chk("core_mode", 32'(m), 32'(core_mode));
        chk("sys_addr", m == ESS_MODE_ADDR ? a ^ x : a, sys_addr);
        chk("sys_wdata", m == ESS_MODE_DATA ? rev(w) : w, sys_wdata);
        chk("sys_valid", 32'h1, 32'(sys_valid));
        chk("page_attr_out", 32'(i[0]), 32'(attr_out));
        chk("big_endian_out", 32'(i[3]), 32'(big_endian_out));
        core(a, 2'h2, i[0], 32'h0);
        chk("core_rdata", w, core_rdata);
        bus(1'b0, ESS_STATUS_ADDR, 32'h0, rd);
        chk("status mode", 32'(m), rd);
    end
endtask
task t_exp;
    for (int b = 0; b < 2; b++) begin
        bus(1'b1, ESS_EXP_CFG1_ADDR, (32'(b) << ESS_EXP_SWAP_BIT) | 32'h300, rd);
        core(32'h0, 2'h2, 1'b1, 32'ha1b2_c3d4);
        chk("exp_sys_valid", 32'h1, 32'(exp_sys_valid));
        chk("exp_sys_wdata", b ? rev(32'h5e4d_3c2b) : 32'h5e4d_3c2b, exp_sys_wdata);
        core(32'h0, 2'h2, 1'b1, 32'h0);
        chk("exp_rdata", 32'h5e4d_3c2b, exp_rdata);
    end
endtask
initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
end
always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
        error_cnt++;
        end_sim();
    end
end
initial begin
    hresetn = 1'b0;
    hsize = 3'h2;
    {hsel, hwrite, htrans, haddr, hwdata, core_valid, core_addr, core_size} = '0;
    {core_page_attr, core_wdata, exp_valid, exp_wdata} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    t_reset();
    t_modes();
    t_exp();
    end_sim();
end
endmodule
